/* src/slcc_pkg.sv */
// package: shared constants and carrier types for the serial line-configuration core
package slcc_pkg;

    // ****************************************
    // frame and timing
    // ****************************************
    localparam int          FRAME_BITS      = 8;
    localparam int          CLK_MHZ         = 10;
    localparam int          HALF_BIT_NS     = 400;
    localparam int          HALF_BIT_CYCLES = (HALF_BIT_NS * CLK_MHZ) / 1000;
    localparam int          FIFO_DEPTH      = 4;
    localparam logic [3:0]  BIT_CNT_RESET   = 4'h0;
    localparam logic [7:0]  SHIFT_RESET     = 8'h00;
    localparam logic [3:0]  PIN_SYNC_RESET  = 4'h1;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic peripheral_enable;
        logic master_sel;
        logic bidirectional_line_sel;
        logic bidir_output_en;
        logic receive_only_sel;
        logic soft_select_mgmt;
        logic internal_select_level;
        logic select_output_en;
    } slcc_cfg_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic slave_select_n;
    } slcc_pins_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } slcc_drive_t;

    typedef enum logic [1:0] {
        SLCC_IDLE  = 2'b00,
        SLCC_SHIFT = 2'b01,
        SLCC_STORE = 2'b11
    } slcc_state_t;

endpackage

/* src/slcc_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module slcc_sync
    import slcc_pkg::*;
#(
    parameter int               WIDTH       = 4,
    // reset to the pins' idle levels so no false edge follows reset
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    initial begin
        if (WIDTH < 1) $error("slcc_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } slcc_sync_state_t;

    slcc_sync_state_t state;
    slcc_sync_state_t next_state;

    // first flop feeds only the second one
    always_comb begin
        next_state.meta   = async_in;
        next_state.stable = state.meta;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{meta: RESET_VALUE, stable: RESET_VALUE};
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;
endmodule
`default_nettype wire

/* src/slcc_fifo.sv */
// small valid/ready fifo for received frames
`timescale 1ns/1ps
`default_nettype none
module slcc_fifo
    import slcc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("slcc_fifo: DEPTH must be power of 2");
    end

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } slcc_fifo_state_t;

    slcc_fifo_state_t state;
    slcc_fifo_state_t next_state;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    assign empty     = state.wr_ptr == state.rd_ptr;
    assign full      = (state.wr_ptr[AW-1:0] == state.rd_ptr[AW-1:0]) && !empty;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem[state.rd_ptr[AW-1:0]];

    always_comb begin
        next_state = state;
        if (push) begin
            next_state.wr_ptr = state.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_state.rd_ptr = state.rd_ptr + 1'b1;
        end
    end

    // storage has no reset: contents are only read once a push made them valid
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[state.wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

/* src/slcc_core.sv */
// line-configuration and role logic of a master/slave serial peripheral
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - only the current master starts a transfer; a slave never shifts on its own.
// - after reset with no line-mode bits set, operation is full-duplex.
// - slave drives MISO and samples MOSI; master drives MOSI and samples MISO.
// - master drives SCK out; slave takes SCK as an input.
// - both ends shift on master clock edges; frame done after all bits shifted.
// - bidirectional mode uses one shared line, direction set by output enable.
// - half-duplex master leaves MISO unused, slave leaves MOSI unused.
// - transmit-only is full-duplex; data on the unused input is meaningless.
// - receive-only slave disables MISO and receives from MOSI while selected.
// - receive-only master disables MOSI and clocks continuously while enabled.
// - receive-only master stops clocking only after the current frame is stored.
// - select pin is monitored as a hardware input for conflict detection.
// - idle nodes stay slaves; the taking node becomes master, then returns.
// - simultaneous mastership requests raise a mode fault event.
// - in multi-master use an active select enables the passive slave MISO driver.
// - hardware select, output disabled, select low while master: fault, fall to slave.
// - hardware-managed slave counts as selected only while its select is low.
// - soft select takes select value from internal level, ignoring the pin.
module slcc_core
    import slcc_pkg::*;
#(
    parameter int FRAME = FRAME_BITS,
    parameter int HALF  = HALF_BIT_CYCLES
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire slcc_cfg_t        cfg,
    input  wire slcc_pins_t       pins_in,
    output slcc_drive_t           pins_out,
    input  wire logic             tx_valid,
    output logic                  tx_ready,
    input  wire logic [FRAME-1:0] tx_data,
    output logic                  rx_valid,
    input  wire logic             rx_ready,
    output logic      [FRAME-1:0] rx_data,
    output logic                  mode_fault_flag,
    input  wire logic             mode_fault_clear,
    output logic                  overrun_flag,
    input  wire logic             overrun_clear,
    output logic                  master_active,
    output logic                  busy
);
    initial begin
        if (FRAME != 8) $error("slcc_core: FRAME must be 8");
        if (HALF < 1 || HALF > 255) $error("slcc_core: HALF must be 1..255");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        slcc_state_t      fsm;
        logic [7:0]       div;
        logic [3:0]       bits;
        logic             sck;
        logic [FRAME-1:0] tx_shift;
        logic [FRAME-1:0] rx_shift;
        logic [FRAME-1:0] rx_hold;
        logic             rx_pend;
        logic             fault;
        logic             ovr;
        logic             sck_prev;
        logic             sel_prev;
        logic             out_bit;
        logic             own_clock;
    } slcc_core_state_t;

    slcc_core_state_t state;
    slcc_core_state_t next_state;
    slcc_pins_t       pins_s;
    logic             fifo_ready;

    // ****************************************
    // pin synchronisation
    // ****************************************
    slcc_sync #(
        .WIDTH       ($bits(slcc_pins_t)),
        .RESET_VALUE (PIN_SYNC_RESET)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in (pins_in),
        .sync_out (pins_s)
    );

    // ****************************************
    // role and line decoding
    // ****************************************
    function automatic logic selected_low(input slcc_cfg_t c, input logic pin_n);
        // soft management ignores the pin
        return c.soft_select_mgmt ? !c.internal_select_level : !pin_n;
    endfunction

    logic is_master;
    logic slave_sel;
    logic rx_only_master;
    logic master_drives_data;
    logic slave_drives_data;
    logic shared_line;
    logic sck_rise;
    logic sck_fall;
    logic fault_event;
    logic master_clock;

    assign is_master   = cfg.peripheral_enable && cfg.master_sel && !state.fault;
    assign slave_sel   = cfg.peripheral_enable && !is_master
                         && selected_low(cfg, pins_s.slave_select_n);
    assign shared_line = cfg.bidirectional_line_sel;
    // continuous clocking in any master receive mode
    assign rx_only_master = is_master && (cfg.receive_only_sel
                            || (shared_line && !cfg.bidir_output_en));
    assign master_drives_data = is_master && !cfg.receive_only_sel
                                && (!shared_line || cfg.bidir_output_en);
    assign slave_drives_data  = slave_sel && !cfg.receive_only_sel
                                && (!shared_line || cfg.bidir_output_en);
    // conflict: another node pulls our select low while we master
    assign fault_event = cfg.peripheral_enable && cfg.master_sel && !cfg.soft_select_mgmt
                         && !cfg.select_output_en && !pins_s.slave_select_n;
    assign sck_rise = pins_s.sck && !state.sck_prev;
    assign sck_fall = !pins_s.sck && state.sck_prev;
    // a frame already clocking finishes when enable or receive-only drops mid-frame
    assign master_clock = is_master
                          || (state.own_clock && cfg.master_sel && !state.fault);

    // ****************************************
    // transfer engine
    // ****************************************
    logic in_bit;
    logic sample_now;
    logic shift_now;
    logic frame_done;

    always_comb begin
        // master samples MISO, slave samples MOSI; shared line uses the driven pin
        if (master_clock) begin
            in_bit = shared_line ? pins_s.mosi : pins_s.miso;
        end else begin
            in_bit = shared_line ? pins_s.miso : pins_s.mosi;
        end
    end

    always_comb begin
        next_state          = state;
        next_state.sck_prev = pins_s.sck;
        next_state.sel_prev = slave_sel;
        sample_now          = 1'b0;
        shift_now           = 1'b0;
        frame_done          = 1'b0;
        tx_ready            = 1'b0;
        // rx stream into fifo; cleared before the case so a frame stored now is kept
        if (state.rx_pend && fifo_ready) begin
            next_state.rx_pend = 1'b0;
        end
        case (state.fsm)
            SLCC_IDLE: begin
                next_state.sck  = 1'b0;
                next_state.own_clock = 1'b0;
                next_state.bits = BIT_CNT_RESET;
                next_state.div  = '0;
                if (is_master && (tx_valid || rx_only_master)) begin
                    // master starts; a slave only waits for the far clock
                    tx_ready            = tx_valid && !rx_only_master;
                    next_state.tx_shift = rx_only_master ? SHIFT_RESET : tx_data;
                    next_state.out_bit  = rx_only_master ? 1'b0 : tx_data[FRAME-1];
                    next_state.own_clock = 1'b1;
                    next_state.fsm      = SLCC_SHIFT;
                end else if (slave_sel && !state.sel_prev) begin
                    tx_ready            = tx_valid;
                    next_state.tx_shift = tx_valid ? tx_data : SHIFT_RESET;
                    next_state.out_bit  = tx_valid ? tx_data[FRAME-1] : 1'b0;
                    next_state.fsm      = SLCC_SHIFT;
                end
            end
            SLCC_SHIFT: begin
                if (master_clock) begin
                    if (state.div == 8'(HALF - 1)) begin
                        next_state.div = '0;
                        next_state.sck = !state.sck;
                        sample_now     = !state.sck;
                        shift_now      = state.sck;
                    end else begin
                        next_state.div = state.div + 8'h01;
                    end
                end else if (!slave_sel) begin
                    next_state.fsm = SLCC_IDLE;
                end else begin
                    sample_now = sck_rise;
                    shift_now  = sck_fall;
                end
                if (sample_now) begin
                    next_state.rx_shift = {state.rx_shift[FRAME-2:0], in_bit};
                    next_state.bits     = state.bits + 4'h1;
                end
                if (shift_now) begin
                    if (state.bits == 4'(FRAME)) begin
                        frame_done = 1'b1;
                    end else begin
                        next_state.tx_shift = {state.tx_shift[FRAME-2:0], 1'b0};
                        next_state.out_bit  = state.tx_shift[FRAME-2];
                    end
                end
                if (frame_done) begin
                    next_state.fsm = SLCC_STORE;
                end
            end
            SLCC_STORE: begin
                // frame is stored before clocking may stop
                next_state.rx_hold = state.rx_shift;
                next_state.rx_pend = 1'b1;
                next_state.bits    = BIT_CNT_RESET;
                next_state.fsm     = SLCC_IDLE;
                next_state.own_clock = 1'b0;
                if (is_master && rx_only_master) begin
                    next_state.fsm       = SLCC_SHIFT;
                    next_state.own_clock = 1'b1;
                end else if (!is_master && slave_sel) begin
                    tx_ready            = tx_valid;
                    next_state.tx_shift = tx_valid ? tx_data : SHIFT_RESET;
                    next_state.out_bit  = tx_valid ? tx_data[FRAME-1] : 1'b0;
                    next_state.fsm      = SLCC_SHIFT;
                end
            end
            default: begin
                next_state.fsm = SLCC_IDLE;
            end
        endcase
        // a second frame over a full buffer is an overrun
        if (state.fsm == SLCC_STORE && state.rx_pend && !fifo_ready) begin
            next_state.ovr = 1'b1;
        end else if (overrun_clear) begin
            next_state.ovr = 1'b0; // reported even in transmit-only use
        end
        // set wins over clear
        if (fault_event) begin
            next_state.fault = 1'b1;
            next_state.fsm   = SLCC_IDLE;
            next_state.own_clock = 1'b0;
        end else if (mode_fault_clear) begin
            next_state.fault = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= '0;
            state.fsm <= SLCC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // receive buffer
    // ****************************************
    slcc_fifo #(
        .WIDTH (FRAME),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (state.rx_pend),
        .in_ready  (fifo_ready),
        .in_data   (state.rx_hold),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ****************************************
    // pin drive
    // ****************************************
    always_comb begin
        pins_out         = '0;
        pins_out.sck_o   = state.sck;
        pins_out.sck_oe  = master_clock;
        if (shared_line) begin
            // master uses MOSI, slave MISO as the shared line; the other pin is free
            pins_out.mosi_o  = state.out_bit;
            pins_out.mosi_oe = master_drives_data;
            pins_out.miso_o  = state.out_bit;
            pins_out.miso_oe = slave_drives_data;
        end else begin
            pins_out.mosi_o  = state.out_bit;
            pins_out.mosi_oe = master_drives_data;
            pins_out.miso_o  = state.out_bit;
            pins_out.miso_oe = slave_drives_data;
        end
    end

    // ****************************************
    // status outputs
    // ****************************************
    assign mode_fault_flag = state.fault;
    assign overrun_flag    = state.ovr;
    assign master_active   = is_master;
    assign busy            = state.fsm != SLCC_IDLE;
endmodule
`default_nettype wire

/* bench/slcc_core_assertions.sv */
// checker: port-level assertions for the serial line-configuration core
`timescale 1ns/1ps
`default_nettype none
module slcc_core_assertions
    import slcc_pkg::*;
#(
    parameter int FRAME = FRAME_BITS,
    parameter int HALF  = HALF_BIT_CYCLES
) (
    input wire logic             sys_clk,
    input wire logic             rst_b,
    input wire slcc_cfg_t        cfg,
    input wire slcc_pins_t       pins_in,
    input wire slcc_drive_t      pins_out,
    input wire logic             tx_valid,
    input wire logic             tx_ready,
    input wire logic [FRAME-1:0] tx_data,
    input wire logic             rx_valid,
    input wire logic             rx_ready,
    input wire logic [FRAME-1:0] rx_data,
    input wire logic             mode_fault_flag,
    input wire logic             mode_fault_clear,
    input wire logic             overrun_flag,
    input wire logic             overrun_clear,
    input wire logic             master_active,
    input wire logic             busy
);
    // ********************************
    // port relations
    // ********************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_sck_slave_off: assert property (
        !cfg.master_sel |-> !pins_out.sck_oe) else $error("sck driven by slave");
    a_sck_master_on: assert property (
        master_active && busy |-> pins_out.sck_oe) else $error("master sck not driven");
    a_slave_no_mosi: assert property (
        !cfg.master_sel |-> !pins_out.mosi_oe) else $error("mosi driven by slave");
    a_master_no_miso: assert property (
        master_active |-> !pins_out.miso_oe) else $error("miso driven by master");
    a_receive_only_sel_miso: assert property (
        cfg.receive_only_sel |-> !pins_out.miso_oe) else $error("miso on in receive-only");
    a_receive_only_sel_mosi: assert property (
        master_active && cfg.receive_only_sel |-> !pins_out.mosi_oe)
        else $error("mosi on in receive-only");
    // a busy gap of up to three cycles is tolerated, a stalled clock is not
    a_receive_only_sel_clock: assert property (
        (master_active && cfg.receive_only_sel)[*4] |-> ##[0:3] busy)
        else $error("receive-only master stopped clocking");
    a_slave_start: assert property (
        $rose(busy) && !cfg.master_sel && !cfg.soft_select_mgmt
        |-> !$past(pins_in.slave_select_n)) else $error("slave began unselected");
    a_fault_set: assert property (
        (cfg.peripheral_enable && cfg.master_sel && !cfg.soft_select_mgmt
         && !cfg.select_output_en && !pins_in.slave_select_n)[*4] |-> mode_fault_flag)
        else $error("select conflict without fault");
    a_fault_slave: assert property (
        mode_fault_flag |-> !master_active) else $error("master kept through fault");
    a_soft_nofault: assert property (
        (cfg.soft_select_mgmt && cfg.internal_select_level)[*3] |-> !$rose(mode_fault_flag))
        else $error("fault under soft select");
    a_rx_hold: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx frame lost");
endmodule
bind slcc_core slcc_core_assertions #(.FRAME(FRAME), .HALF(HALF)) slcc_core_assertions_i (
    .sys_clk, .rst_b, .cfg, .pins_in, .pins_out, .tx_valid, .tx_ready, .tx_data,
    .rx_valid, .rx_ready, .rx_data, .mode_fault_flag, .mode_fault_clear,
    .overrun_flag, .overrun_clear, .master_active, .busy);
`default_nettype wire

/* bench/slcc_partner.sv */
// partner: external serial node acting as slave or as master
`timescale 1ns/1ps
`default_nettype none
module slcc_partner (
    input  wire logic       sck_l,
    input  wire logic       mosi_l,
    input  wire logic       miso_l,
    input  wire logic       mst,
    input  wire logic       go,
    input  wire logic [7:0] tx,
    output logic            sck,
    output logic            mosi,
    output logic            miso,
    output logic            sel_n,
    output logic            busy,
    output logic [7:0]      rx
);
    // ********************************
    // shift path
    // ********************************
    logic [7:0] sh = 8'h00;
    initial begin
        sck = 1'b0;
        sel_n = 1'b1;
        busy = 1'b0;
        rx = 8'h00;
    end
    // an undriven line shows the inverse so a stale bit never passes as data
    assign mosi = mst ? sh[7] : ~sh[7];
    assign miso = mst ? ~sh[7] : sh[7];
    always @(posedge sck_l) rx <= {rx[6:0], mst ? miso_l : mosi_l};
    // rotating keeps the same byte for every frame of a burst
    always @(negedge sck_l) sh <= {sh[6:0], sh[7]};
    always @(posedge go) begin
        sh = tx;
        if (mst) begin
            busy = 1'b1;
            sel_n = 1'b0;
            // half a system cycle off so every SCK edge and the select release land between clock edges
            #850;
            repeat (8) begin
                #400 sck = 1'b1;
                #400 sck = 1'b0;
            end
            #400 sel_n = 1'b1;
            busy = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* bench/slcc_core_test.sv */
// testbench: drives the core against the partner node and checks results
`timescale 1ns/1ps
`default_nettype none
module slcc_core_test
    import slcc_pkg::*;
;
    logic        sys_clk = 1'b0, rst_b = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
    logic        mode_fault_clear = 1'b0, overrun_clear = 1'b0, p_mst = 1'b0, p_go = 1'b0;
    logic        tx_ready, rx_valid, mode_fault_flag, overrun_flag, master_active, busy;
    logic        p_sck, p_mosi, p_miso, p_sel_n, p_busy, sck_l, mosi_l, miso_l;
    logic [7:0]  tx_data = 8'h00, p_tx = 8'h00, rx_data, p_rx;
    slcc_cfg_t   cfg = '0;
    slcc_pins_t  pins_in;
    slcc_drive_t pins_out;
    int          err_total = 0, tests_run = 0, cyc = 0, rises = 0;

    always #50 sys_clk = ~sys_clk;
    assign sck_l   = pins_out.sck_oe ? pins_out.sck_o : p_sck;
    assign mosi_l  = pins_out.mosi_oe ? pins_out.mosi_o : p_mosi;
    assign miso_l  = pins_out.miso_oe ? pins_out.miso_o : p_miso;
    assign pins_in = '{sck_l, mosi_l, miso_l, p_sel_n};

    slcc_core #(.FRAME(8), .HALF(4)) slcc_core_i (
        .sys_clk, .rst_b, .cfg, .pins_in, .pins_out, .tx_valid, .tx_ready, .tx_data,
        .rx_valid, .rx_ready, .rx_data, .mode_fault_flag, .mode_fault_clear,
        .overrun_flag, .overrun_clear, .master_active, .busy);
    slcc_partner slcc_partner_i (
        .sck_l, .mosi_l, .miso_l, .mst(p_mst), .go(p_go), .tx(p_tx), .sck(p_sck),
        .mosi(p_mosi), .miso(p_miso), .sel_n(p_sel_n), .busy(p_busy), .rx(p_rx));

    // ********************************
    // tasks
    // ********************************
    task automatic report_and_stop;
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(string n, logic e, logic g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic idle(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // k: 0 accept pulse, 1 frame waiting, 2 core idle; bounded so a hang shows
    task automatic wait_for(int k);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (n < 300 && (k == 0 ? tx_ready : k == 1 ? rx_valid : !busy) !== 1'b1);
    endtask
    task automatic set_cfg(logic [7:0] c);
        @(posedge sys_clk);
        cfg <= slcc_cfg_t'(c);
    endtask
    task automatic send(logic [7:0] d);
        @(posedge sys_clk);
        tx_valid <= 1'b1;
        tx_data  <= d;
        wait_for(0);
        @(posedge sys_clk);
        tx_valid <= 1'b0;
    endtask
    task automatic pop(logic [7:0] e);
        wait_for(1);
        chk8("rx_data", e, rx_data);
        @(posedge sys_clk);
        rx_ready <= 1'b1;
        @(posedge sys_clk);
        rx_ready <= 1'b0;
    endtask
    // mode and byte settle a cycle before the start strobe
    task automatic pgo(logic m, logic [7:0] b);
        @(posedge sys_clk);
        p_mst <= m;
        p_tx  <= b;
        @(posedge sys_clk);
        p_go <= 1'b1;
        @(posedge sys_clk);
        p_go <= 1'b0;
        #10;
        wait (p_busy === 1'b0);
    endtask
    task automatic clr_flags;
        @(posedge sys_clk);
        mode_fault_clear <= 1'b1;
        overrun_clear    <= 1'b1;
        @(posedge sys_clk);
        mode_fault_clear <= 1'b0;
        overrun_clear    <= 1'b0;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    always @(posedge sck_l) rises++;

    // ********************************
    // sequence
    // ********************************
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        idle(4);
        chk8("pins_out", 8'h00, {2'h0, pins_out});
        set_cfg(8'hc6);
        pgo(1'b0, 8'h3c);
        // four frames fill the fifo, one waits in hold, the sixth overruns
        for (int i = 0; i < 6; i++) send(8'ha0 + i[7:0]);
        wait_for(2);
        idle(2);
        chk8("partner_rx", 8'ha5, p_rx);
        chk1("overrun_flag", 1'b1, overrun_flag);
        chk1("mode_fault_flag", 1'b0, mode_fault_flag);
        for (int i = 0; i < 5; i++) pop(8'h3c);
        idle(1);
        chk1("rx_valid", 1'b0, rx_valid);
        clr_flags();
        pgo(1'b0, 8'h96);
        rises = 0;
        set_cfg(8'hce);
        for (int i = 0; i < 3; i++) pop(8'h96);
        idle(10);
        set_cfg(8'hc6);
        wait_for(2);
        pop(8'h96);
        idle(20);
        chk1("busy", 1'b0, busy);
        chk8("sck_rises", 8'h20, rises[7:0]);
        for (int r = 0; r < 3; r++) begin
            set_cfg(r == 0 ? 8'h80 : r == 1 ? 8'h88 : 8'h86);
            fork
                if (r == 0) send(8'hc3);
                pgo(1'b1, 8'h69);
                begin
                    idle(40);
                    chk1("miso_oe", r == 0, pins_out.miso_oe);
                end
            join
            idle(4);
            chk1("miso_oe", 1'b0, pins_out.miso_oe);
            if (r == 0) chk8("partner_rx", 8'hc3, p_rx);
            if (r < 2) pop(8'h69);
            else chk1("rx_valid", 1'b0, rx_valid);
        end
        set_cfg(8'hc0);
        idle(4);
        chk1("master_active", 1'b1, master_active);
        pgo(1'b1, 8'h55);
        chk1("mode_fault_flag", 1'b1, mode_fault_flag);
        chk1("master_active", 1'b0, master_active);
        // released select must pass the synchroniser, else the set beats the clear
        idle(4);
        clr_flags();
        idle(2);
        chk1("mode_fault_flag", 1'b0, mode_fault_flag);
        report_and_stop();
    end
endmodule
`default_nettype wire
